// ==== logic/lintr_core.sv ====
// Overview of operation
// - Enable held low for the sleep delay enters sleep and drops the inhibit output within 50 to 91 us.
// - A dominant bus in sleep wakes the device only after persisting through a 40 to 100 us filter.
// - Enable rising in sleep wakes the device with inhibit high within 15 us.
// - A wake pin change in sleep wakes the device after persisting 10 to 70 us.
// - Transmit data dominant for 3.75 to 6.25 ms forces the bus recessive while the receiver stays active.
// - After entering normal mode the first dominant bit is held off for about 50 us, at most 80 us.
// - On fast baud entry receive data is driven low for 1.875 to 6.25 us after enable rises.
// - Enable high means normal mode; sleep entry needs the wake pin steady over the sleep delay.
// - In sleep receive data floats, and a recognised wake from pin or bus pulls it low.
// - A further toggle exits fast baud and receive data stays high at its end.
// - In normal mode low transmit data drives the bus dominant, and receive data mirrors the bus.
`timescale 1ns/1ps
`default_nettype none
module lintr_core
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clock_en,
   input  wire logic enable_in,
   input  wire logic txd_in,
   input  wire logic bus_in,
   input  wire logic wake_in,
   output logic      bus_drive_low,
   output logic      rxd_out,
   output logic      rxd_oe,
   output logic      regulator_inhibit_out,
   output logic      fast_baud
);
   // ------------------------------------------------------------
   // Input sampling
   // ------------------------------------------------------------
   lintr_pkg::lintr_in_t pin;

   lintr_sync u_sync
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (clock_en),
      .raw     ({enable_in, txd_in, bus_in, wake_in}),
      .rst_val (4'hf),
      .clean   (pin)
   );

   function automatic logic [lintr_pkg::CNT_W-1:0] inc(input logic [lintr_pkg::CNT_W-1:0] v);
      inc = v + 18'h00001;
   endfunction

   function automatic logic reached(input logic [lintr_pkg::CNT_W-1:0] v, input int unsigned lim);
      reached = (v >= lim[lintr_pkg::CNT_W-1:0]);
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   lintr_pkg::lintr_mode_t     mode;
   lintr_pkg::lintr_mode_t     next_mode;
   logic [lintr_pkg::CNT_W-1:0] mcnt;
   logic [lintr_pkg::CNT_W-1:0] next_mcnt;
   logic [lintr_pkg::CNT_W-1:0] dcnt;
   logic [lintr_pkg::CNT_W-1:0] next_dcnt;
   logic [lintr_pkg::CNT_W-1:0] hcnt;
   logic [lintr_pkg::CNT_W-1:0] next_hcnt;
   logic [lintr_pkg::CNT_W-1:0] acnt;
   logic [lintr_pkg::CNT_W-1:0] next_acnt;
   logic                       wake_ref;
   logic                       next_wake_ref;
   logic                       wake_flag;
   logic                       next_wake_flag;
   logic                       dom_lock;
   logic                       next_dom_lock;
   logic                       tx_seen_low;
   logic                       next_tx_seen_low;
   logic                       next_fast_baud;
   logic                       regulator_on;
   logic                       next_regulator_on;

   // ------------------------------------------------------------
   // Mode control
   // ------------------------------------------------------------
   always_comb
   begin
      next_mode        = mode;
      next_mcnt        = inc(mcnt);
      next_wake_ref    = wake_ref;
      next_wake_flag   = wake_flag;
      next_regulator_on = regulator_on;
      next_fast_baud   = fast_baud;
      next_tx_seen_low = tx_seen_low;
      next_acnt        = (acnt != '0) ? acnt - 18'h00001 : acnt;
      case (mode)
         lintr_pkg::LINTR_NORMAL:
         begin
            next_mcnt        = '0;
            next_tx_seen_low = 1'b0;
            next_wake_ref    = pin.wake;
            if (!pin.enable)
            begin
               next_mode = lintr_pkg::LINTR_PRESLEEP;
            end
         end
         lintr_pkg::LINTR_PRESLEEP:
         begin
            if (!pin.txd)
            begin
               next_tx_seen_low = 1'b1;
            end
            if (pin.enable)
            begin
               next_mode = lintr_pkg::LINTR_NORMAL;
               // Short enable pulse with a transmit low inside it toggles baud
               if (tx_seen_low && pin.txd && mcnt <= lintr_pkg::TOGGLE_EN_MAX_CYC[lintr_pkg::CNT_W-1:0])
               begin
                  next_fast_baud = ~fast_baud;
                  if (!fast_baud)
                  begin
                     next_acnt = lintr_pkg::ACK_CYC[lintr_pkg::CNT_W-1:0];
                  end
               end
            end
            else if (pin.wake != wake_ref)
            begin
               next_mcnt     = '0;
               next_wake_ref = pin.wake;
            end
            else if (reached(mcnt, lintr_pkg::SLEEP_ENTRY_DELAY_CYC))
            begin
               next_mode  = lintr_pkg::LINTR_SLEEP;
               next_regulator_on = 1'b0;
               next_mcnt  = '0;
               next_wake_flag = 1'b0;
            end
         end
         lintr_pkg::LINTR_SLEEP:
         begin
            if (pin.enable)
            begin
               next_mode = lintr_pkg::LINTR_WAKING;
               next_mcnt = '0;
            end
            else if (!pin.bus)
            begin
               if (reached(mcnt, lintr_pkg::BUS_WAKE_FILTER_TIME_CYC))
               begin
                  next_regulator_on = 1'b1;
                  next_wake_flag = 1'b1;
                  next_wake_ref  = pin.wake;
               end
            end
            else if (pin.wake != wake_ref)
            begin
               if (reached(mcnt, lintr_pkg::LOCAL_WAKE_FILTER_TIME_CYC))
               begin
                  next_regulator_on = 1'b1;
                  next_wake_flag = 1'b1;
                  next_wake_ref  = pin.wake;
               end
            end
            else
            begin
               next_mcnt = '0;
            end
         end
         lintr_pkg::LINTR_WAKING:
         begin
            if (!pin.enable)
            begin
               next_mode = lintr_pkg::LINTR_SLEEP;
               next_mcnt = '0;
            end
            else if (reached(mcnt, lintr_pkg::ENABLE_WAKE_FILTER_TIME_CYC))
            begin
               next_mode      = lintr_pkg::LINTR_NORMAL;
               next_regulator_on = 1'b1;
               next_wake_flag = 1'b0;
            end
         end
         default:
         begin
            next_mode = lintr_pkg::LINTR_NORMAL;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Transmit path: first-dominant holdoff and dominant timeout
   // ------------------------------------------------------------
   always_comb
   begin
      next_hcnt     = hcnt;
      next_dcnt     = '0;
      next_dom_lock = dom_lock;
      if (mode != lintr_pkg::LINTR_NORMAL)
      begin
         next_hcnt = '0;
      end
      else if (!reached(hcnt, lintr_pkg::FIRST_DOMINANT_HOLDOFF_CYC))
      begin
         next_hcnt = inc(hcnt);
      end
      if (pin.txd)
      begin
         next_dom_lock = 1'b0;
      end
      else if (mode == lintr_pkg::LINTR_NORMAL)
      begin
         next_dcnt = inc(dcnt);
         if (reached(dcnt, lintr_pkg::DOMINANT_TIMEOUT_CYC))
         begin
            next_dom_lock = 1'b1;
            next_dcnt     = dcnt;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mode        <= lintr_pkg::LINTR_NORMAL;
         mcnt        <= '0;
         dcnt        <= '0;
         hcnt        <= '0;
         acnt        <= '0;
         wake_ref    <= 1'b1;
         wake_flag   <= 1'b0;
         dom_lock    <= 1'b0;
         tx_seen_low <= 1'b0;
         fast_baud   <= 1'b0;
         regulator_on <= 1'b1;
      end
      else if (clock_en)
      begin
         mode        <= next_mode;
         mcnt        <= next_mcnt;
         dcnt        <= next_dcnt;
         hcnt        <= next_hcnt;
         acnt        <= next_acnt;
         wake_ref    <= next_wake_ref;
         wake_flag   <= next_wake_flag;
         dom_lock    <= next_dom_lock;
         tx_seen_low <= next_tx_seen_low;
         fast_baud   <= next_fast_baud;
         regulator_on <= next_regulator_on;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic normal;

   assign normal = (mode == lintr_pkg::LINTR_NORMAL);

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         bus_drive_low         <= 1'b0;
         rxd_out               <= 1'b1;
         rxd_oe                <= 1'b1;
         regulator_inhibit_out <= 1'b1;
      end
      else if (clock_en)
      begin
         bus_drive_low <= normal && !pin.txd && !dom_lock && !next_dom_lock
                          && reached(hcnt, lintr_pkg::FIRST_DOMINANT_HOLDOFF_CYC);
         if (acnt != '0)
         begin
            rxd_out <= 1'b0;
            rxd_oe  <= 1'b1;
         end
         else if (mode == lintr_pkg::LINTR_SLEEP || mode == lintr_pkg::LINTR_WAKING)
         begin
            rxd_out <= 1'b0;
            rxd_oe  <= wake_flag;
         end
         else
         begin
            rxd_out <= pin.bus;
            rxd_oe  <= 1'b1;
         end
         regulator_inhibit_out <= regulator_on;
      end
   end
endmodule
`default_nettype wire

// ==== logic/lintr_pkg.sv ====
package lintr_pkg;
   // ------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 20000;

   // ------------------------------------------------------------
   // Times in picoseconds, as specified
   // ------------------------------------------------------------
   localparam longint SLEEP_MIN_PS      = 64'd50000000;     // 50 us
   localparam longint SLEEP_MAX_PS      = 64'd91000000;     // 91 us
   localparam longint SLEEP_TYP_PS      = 64'd70000000;     // 70 us
   localparam longint BUS_WAKE_MIN_PS   = 64'd40000000;     // 40 us
   localparam longint BUS_WAKE_TYP_PS   = 64'd70000000;     // 70 us
   localparam longint BUS_WAKE_MAX_PS   = 64'd100000000;    // 100 us
   localparam longint EN_WAKE_MAX_PS    = 64'd15000000;     // 15 us
   localparam longint LOC_WAKE_MIN_PS   = 64'd10000000;     // 10 us
   localparam longint LOC_WAKE_TYP_PS   = 64'd48000000;     // 48 us
   localparam longint LOC_WAKE_MAX_PS   = 64'd70000000;     // 70 us
   localparam longint DOM_TYP_PS        = 64'd5000000000;   // 5.0 ms
   localparam longint FIRST_DOM_TYP_PS  = 64'd50000000;     // 50 us
   localparam longint FIRST_DOM_MAX_PS  = 64'd80000000;     // 80 us
   localparam longint TOGGLE_EN_MAX_PS  = 64'd45000000;     // 45 us
   localparam longint ACK_MIN_PS        = 64'd1875000;      // 1.875 us
   localparam longint ACK_MAX_PS        = 64'd6250000;      // 6.25 us

   // ------------------------------------------------------------
   // Cycle counts
   // ------------------------------------------------------------
   function automatic int unsigned cyc(input longint t_ps);
      cyc = int'(t_ps / CLK_PERIOD_PS);
   endfunction

   localparam int unsigned SLEEP_ENTRY_DELAY_CYC      = cyc(SLEEP_TYP_PS);   // Midway 50..91
   localparam int unsigned BUS_WAKE_FILTER_TIME_CYC   = cyc(BUS_WAKE_TYP_PS);
   localparam int unsigned ENABLE_WAKE_FILTER_TIME_CYC = cyc(EN_WAKE_MAX_PS) / 2;
   localparam int unsigned LOCAL_WAKE_FILTER_TIME_CYC = cyc(LOC_WAKE_TYP_PS);
   localparam int unsigned DOMINANT_TIMEOUT_CYC       = cyc(DOM_TYP_PS);
   localparam int unsigned FIRST_DOMINANT_HOLDOFF_CYC = cyc(FIRST_DOM_TYP_PS);
   localparam int unsigned TOGGLE_EN_MAX_CYC          = cyc(TOGGLE_EN_MAX_PS);
   localparam int unsigned ACK_CYC                    = cyc(64'd4000000);  // 4 us, inside 1.875..6.25
   localparam int unsigned TOGGLE_SETUP_CYC           = cyc(64'd12500000) / 2;

   localparam int CNT_W = 18;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      LINTR_NORMAL   = 2'b00,
      LINTR_PRESLEEP = 2'b01,
      LINTR_SLEEP    = 2'b10,
      LINTR_WAKING   = 2'b11
   } lintr_mode_t;

   typedef struct packed
   {
      logic enable;
      logic txd;
      logic bus;
      logic wake;
   } lintr_in_t;
endpackage

// ==== logic/lintr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module lintr_sync
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [3:0]  raw,
   input  wire logic [3:0]  rst_val,
   output logic      [3:0]  clean
);
   // ------------------------------------------------------------
   // Three-stage sampling, change taken once stages two and three agree
   // ------------------------------------------------------------
   logic [3:0] s1;
   logic [3:0] s2;
   logic [3:0] s3;
   logic [3:0] next_clean;

   always_comb
   begin
      next_clean = clean;
      for (int i = 0; i < 4; i++)
      begin
         if (s2[i] == s3[i])
         begin
            next_clean[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s1    <= rst_val;
         s2    <= rst_val;
         s3    <= rst_val;
         clean <= rst_val;
      end
      else if (ce)
      begin
         s1    <= raw;
         s2    <= s1;
         s3    <= s2;
         clean <= next_clean;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/lintr_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module lintr_core_sva
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_en,
   input wire logic enable_in,
   input wire logic txd_in,
   input wire logic bus_in,
   input wire logic wake_in,
   input wire logic bus_drive_low,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   input wire logic regulator_inhibit_out,
   input wire logic fast_baud
);
   // ----------
   // Pin age counters
   // ----------
   logic [19:0] en_lo;
   logic [19:0] en_hi;
   logic [19:0] tx_lo;
   logic [19:0] bus_lo;
   logic [19:0] wk_age;
   logic [19:0] rx_lo;
   logic        wake_q;

   function automatic logic [19:0] sat(input logic [19:0] c);
      sat = c + 20'(c != 20'hfffff);
   endfunction

   always_ff @(posedge clock)
   begin
      wake_q <= wake_in;
      en_lo  <= (!rst_n || enable_in) ? 20'h0 : sat(en_lo);
      en_hi  <= (!rst_n || !enable_in) ? 20'h0 : sat(en_hi);
      tx_lo  <= (!rst_n || txd_in) ? 20'h0 : sat(tx_lo);
      bus_lo <= (!rst_n || bus_in) ? 20'h0 : sat(bus_lo);
      wk_age <= (!rst_n || wake_in != wake_q) ? 20'h0 : sat(wk_age);
      rx_lo  <= (!rst_n || rxd_out) ? 20'h0 : sat(rx_lo);
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n || !clock_en);

   a_sleep_window: assert property ($fell(regulator_inhibit_out) |-> en_lo >= 2500 && en_lo <= 4550)
      else $error("inhibit fell outside the sleep delay");
   a_enable_wake: assert property ($rose(enable_in) && !regulator_inhibit_out |-> ##[1:750] regulator_inhibit_out)
      else $error("enable wake too slow");
   a_wake_window: assert property (!enable_in && $rose(regulator_inhibit_out) |->
      (bus_lo >= 2000 && bus_lo <= 5000) || (wk_age >= 500 && wk_age <= 3500))
      else $error("wake outside its filter window");
   a_wake_flag: assert property (!enable_in && $rose(regulator_inhibit_out) |-> ##[0:2] (rxd_oe && !rxd_out))
      else $error("wake not flagged on rxd");
   a_first_holdoff: assert property (bus_drive_low |-> en_hi >= 2000)
      else $error("dominant during holdoff");
   a_dom_drive: assert property (en_hi >= 4100 && tx_lo >= 8 && tx_lo <= 180000 |-> bus_drive_low)
      else $error("dominant not driven");
   a_tx_recessive: assert property (txd_in [*8] |=> !bus_drive_low)
      else $error("bus driven while txd high");
   a_dom_timeout: assert property (tx_lo >= 312600 |-> !bus_drive_low)
      else $error("dominant timeout missing");
   a_ack_pulse: assert property ($rose(fast_baud) |->
      ##[0:4] !rxd_out ##[90:312] (rxd_out && rx_lo >= 94 && rx_lo <= 312))
      else $error("fast baud ack wrong");
   a_exit_quiet: assert property ($fell(fast_baud) |-> rxd_out [*8])
      else $error("rxd pulsed on fast baud exit");

   c_sleep: cover property ($fell(regulator_inhibit_out));
   c_wake: cover property (!enable_in && $rose(regulator_inhibit_out));
   c_fast: cover property ($rose(fast_baud));
endmodule

bind lintr_core lintr_core_sva chk
(
   .clock                 (clock),
   .rst_n                 (rst_n),
   .clock_en              (clock_en),
   .enable_in             (enable_in),
   .txd_in                (txd_in),
   .bus_in                (bus_in),
   .wake_in               (wake_in),
   .bus_drive_low         (bus_drive_low),
   .rxd_out               (rxd_out),
   .rxd_oe                (rxd_oe),
   .regulator_inhibit_out (regulator_inhibit_out),
   .fast_baud             (fast_baud)
);
`default_nettype wire

// ==== testbench/lintr_mcu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lintr_mcu_model
(
   input  wire logic clock,
   input  wire logic rxd_out,
   input  wire logic rxd_oe,
   output var  logic enable,
   output var  logic txd,
   output wire logic rxd_pin
);
   // ----------
   // Controller pins
   // ----------
   assign rxd_pin = rxd_oe ? rxd_out : 1'b1;   // External pull-up on a floating rxd

   initial
   begin
      enable = 1'b1;
      txd    = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic toggle();
      enable = 1'b0;   // Low pulse of 2100 cycles
      hold(700);
      txd = 1'b0;
      hold(700);
      txd = 1'b1;
      hold(700);
      enable = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== testbench/lin_transceiver_mode_timing_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module lin_transceiver_mode_timing_test;
   logic clock      = 1'b0;
   logic rst_n      = 1'b0;
   logic remote_dom = 1'b0;
   logic wake_in    = 1'b0;
   logic clock_en   = 1'b1;
   wire  logic enable_in;
   wire  logic txd_in;
   wire  logic bus_in;
   wire  logic rxd_pin;
   logic bus_drive_low;
   logic rxd_out;
   logic rxd_oe;
   logic inhibit;
   logic fast_baud;
   int   error_cnt = 0;
   int   checks    = 0;

   // ----------
   // Bench and bus
   // ----------
   always #10 clock = ~clock;
   assign bus_in = !(bus_drive_low || remote_dom);   // Wired bus with pull-up

   lintr_mcu_model mcu
   (
      .clock   (clock),
      .rxd_out (rxd_out),
      .rxd_oe  (rxd_oe),
      .enable  (enable_in),
      .txd     (txd_in),
      .rxd_pin (rxd_pin)
   );

   lintr_core uut
   (
      .clock                 (clock),
      .rst_n                 (rst_n),
      .clock_en              (clock_en),
      .enable_in             (enable_in),
      .txd_in                (txd_in),
      .bus_in                (bus_in),
      .wake_in               (wake_in),
      .bus_drive_low         (bus_drive_low),
      .rxd_out               (rxd_out),
      .rxd_oe                (rxd_oe),
      .regulator_inhibit_out (inhibit),
      .fast_baud             (fast_baud)
   );

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic go_sleep();
      mcu.enable = 1'b0;
      cyc(4600);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic test_tx();
      cyc(100);
      mcu.txd = 1'b0;
      cyc(50);
      `CHK(bus_drive_low, 1'b0)
      cyc(4100);
      `CHK(bus_drive_low, 1'b1)
      `CHK(rxd_pin, 1'b0)
      mcu.txd = 1'b1;
      cyc(10);
      `CHK(bus_drive_low, 1'b0)
      `CHK(rxd_pin, 1'b1)
      remote_dom = 1'b1;
      cyc(10);
      `CHK(rxd_pin, 1'b0)
      remote_dom = 1'b0;
      cyc(10);
      $display("test_tx done");
   endtask

   task automatic test_freeze();
      clock_en   = 1'b0;
      remote_dom = 1'b1;
      cyc(20);
      `CHK(rxd_pin, 1'b1)
      clock_en = 1'b1;
      cyc(10);
      `CHK(rxd_pin, 1'b0)
      remote_dom = 1'b0;
      cyc(10);
      `CHK(rxd_pin, 1'b1)
      $display("test_freeze done");
   endtask

   task automatic test_sleep();
      mcu.enable = 1'b0;
      cyc(2450);
      `CHK(inhibit, 1'b1)
      cyc(2100);
      `CHK(inhibit, 1'b0)
      `CHK(rxd_oe, 1'b0)
      `CHK(rxd_pin, 1'b1)
      mcu.enable = 1'b1;
      cyc(750);
      `CHK(inhibit, 1'b1)
      `CHK(rxd_oe, 1'b1)
      cyc(4100);
      $display("test_sleep done");
   endtask

   task automatic test_bus_wake();
      go_sleep();
      remote_dom = 1'b1;
      cyc(1950);
      `CHK(inhibit, 1'b0)
      cyc(1650);
      `CHK(inhibit, 1'b1)
      `CHK(rxd_pin, 1'b0)
      remote_dom = 1'b0;
      mcu.enable = 1'b1;
      cyc(4100);
      $display("test_bus_wake done");
   endtask

   task automatic test_wake_pin();
      go_sleep();
      wake_in = 1'b1;
      cyc(480);
      `CHK(inhibit, 1'b0)
      cyc(2020);
      `CHK(inhibit, 1'b1)
      `CHK(rxd_pin, 1'b0)
      mcu.enable = 1'b1;
      cyc(4100);
      $display("test_wake_pin done");
   endtask

   task automatic test_toggle();
      mcu.toggle();
      cyc(10);
      `CHK(fast_baud, 1'b1)
      `CHK(rxd_pin, 1'b0)
      cyc(84);
      `CHK(rxd_pin, 1'b0)
      cyc(218);
      `CHK(rxd_pin, 1'b1)
      mcu.toggle();
      for (int i = 0; i < 8; i++)
      begin
         cyc(1);
         `CHK(rxd_pin, 1'b1)
      end
      `CHK(fast_baud, 1'b0)
      $display("test_toggle done");
   endtask

   initial
   begin
      cyc(60000);
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      stop_test();
   end

   initial
   begin
      cyc(3);
      rst_n = 1'b1;
      test_tx();
      test_freeze();
      test_sleep();
      test_bus_wake();
      test_wake_pin();
      test_toggle();
      stop_test();
   end
endmodule
`default_nettype wire
